//--- vio_map.svh
/*
  constants for the virtual i/o mapper: register offsets, selector and delay limits,
  the fault code, analog thresholds and timing counts.
  assumes the includer is a design file of the vio mapper.
*/
`ifndef VIO_MAP_SVH
`define VIO_MAP_SVH

// byte addresses, one word each
`define VIO_OFS_VIN_FUNC0    8'h00
`define VIO_OFS_VIN_MODE     8'h14
`define VIO_OFS_VIN_LEVEL    8'h18
`define VIO_OFS_AN_FUNC0     8'h1c
`define VIO_OFS_AN_POL       8'h28
`define VIO_OFS_VOUT_FUNC0   8'h2c
`define VIO_OFS_VOUT_DLY0    8'h40
`define VIO_OFS_VOUT_POL     8'h54
`define VIO_OFS_STATE        8'h58
`define VIO_OFS_IRQ_STAT     8'h5c
`define VIO_OFS_IRQ_MASK     8'h60
`define VIO_OFS_VIN_STATE    8'h64

`define VIO_FUNC_MAX_IN      6'h3b
`define VIO_FUNC_MAX_OUT     6'h28
`define VIO_FUNC_FWD         6'h01
`define VIO_FUNC_UFAULT1     6'h2c
`define VIO_FUNC_AI1_LIMIT   6'h1f
`define VIO_USER_FAULT_ONE   8'h1b
`define VIO_DLY_MAX          16'h8ca0

// analog codes: full scale 10 V over 12 bits
`define VIO_AN_HI_MV         7000
`define VIO_AN_LO_MV         3000
`define VIO_AN_FS_MV         10000

`define VIO_TICK_NS          100000000
`define VIO_CLK_NS           10

`endif

//--- vio_pkg.sv
/*
  types for the virtual i/o mapper.
  assumes vio_map.svh supplies the numeric constants.
*/
package vio_pkg;
  typedef logic [5:0] vio_func_type;
  typedef struct packed {
    logic [4:0] vin_active;
    logic       forward_run_cmd;
    logic       user_fault;
    logic [7:0] user_fault_one_code;
  } vio_status_type;
  typedef enum logic [2:0] {
    VIO_ST_INIT  = 3'b001,
    VIO_ST_RUN   = 3'b010,
    VIO_ST_FAULT = 3'b100
  } vio_state_type;
endpackage : vio_pkg

//--- vio_mapper.sv
/*
  virtual i/o mapper: five virtual inputs, five virtual outputs with delay
  and polarity, three analog channels used as digital inputs; avalon-mm slave.
  assumes physical lines and analog codes are asynchronous and are
  synchronised here; function vectors come from logic on clk.
*/
`timescale 1ns/1ps
`include "vio_map.svh"
module vio_mapper #(
  parameter int NUM_V     = 5,
  parameter int NUM_AN    = 3,
  parameter int AN_W      = 12,
  parameter int TICK_CYC  = `VIO_TICK_NS / `VIO_CLK_NS
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // avalon-mm slave
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // terminals and analog channels
  input  wire logic [NUM_V-1:0]     physical_input_line,
  input  wire logic [NUM_AN*AN_W-1:0] analog_channel,
  // status function vector, index is selector value
  input  wire logic [40:0]          out_status_func,
  // to drive input-function logic
  output logic [NUM_V-1:0]          virtual_output,
  output logic [NUM_V-1:0]          virtual_input,
  output logic [NUM_AN-1:0]         analog_as_input,
  output vio_pkg::vio_status_type   drive_status,
  output logic                      irq
);
  initial begin
    if (NUM_V != 5 || NUM_AN != 3 || AN_W < 8 || AN_W > 16 || TICK_CYC < 1)
      $error("vio_mapper: unsupported parameters");
  end

  localparam logic [AN_W-1:0] AN_HI =
    AN_W'((`VIO_AN_HI_MV * ((1 << AN_W) - 1) + `VIO_AN_FS_MV - 1) / `VIO_AN_FS_MV);
  localparam logic [AN_W-1:0] AN_LO =
    AN_W'((`VIO_AN_LO_MV * ((1 << AN_W) - 1)) / `VIO_AN_FS_MV);

  // a narrow converter could round the two thresholds together and lose the
  // hold band, which would make the analog input chatter near the limits
  initial begin
    if (AN_HI <= AN_LO)
      $error("vio_mapper: analog thresholds overlap");
  end

  vio_pkg::vio_func_type vin_func_r  [NUM_V];
  vio_pkg::vio_func_type vout_func_r [NUM_V];
  vio_pkg::vio_func_type an_func_r   [NUM_AN];
  logic [15:0]           vout_dly_r  [NUM_V];
  logic [NUM_V-1:0]      vin_source_mode_r;
  logic [NUM_V-1:0]      vin_stored_level_r;
  logic [NUM_V-1:0]      vout_polarity_r;
  logic [NUM_AN-1:0]     analog_as_input_polarity_r;
  logic [1:0]            irq_stat_r;
  logic [1:0]            irq_mask_r;
  logic [NUM_V-1:0]      phys_s1_r;
  logic [NUM_V-1:0]      phys_s2_r;
  logic [NUM_AN*AN_W-1:0] an_s1_r;
  logic [NUM_AN*AN_W-1:0] an_s2_r;
  logic [NUM_AN-1:0]     an_level_r;
  logic [NUM_V-1:0]      vout_raw;
  logic [NUM_V-1:0]      vout_held_r;
  logic [31:0]           tick_cnt_r;
  logic                  tick;
  logic                  wr_en;
  logic                  fault_ev;
  logic                  fwd_now;
  logic                  ufault_now;
  logic                  ufault_prev_r;
  logic                  rd_done_r;
  logic                  vin_func_ok;
  logic                  vout_func_ok;
  logic                  dly_ok;
  logic [1:0]            irq_clr;
  logic [1:0]            irq_set;
  vio_pkg::vio_state_type state_r;

  // reads insert one wait state: read data come from a flip-flop, so they are
  // loaded in the first cycle and stand at the edge that sees waitrequest low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_done_r <= 1'b0;
    end else begin
      // high for one cycle per read, so a back-to-back read waits again
      rd_done_r <= avs_read && !rd_done_r;
    end
  end
  assign avs_waitrequest = avs_read && !rd_done_r;
  // writes never wait and take effect on their first edge
  assign wr_en = avs_write && !avs_waitrequest;

  // whole-word range checks: a value with stray upper bits is refused rather
  // than folded onto a legal selector or delay
  assign vin_func_ok  = (avs_writedata <= {26'h0, `VIO_FUNC_MAX_IN});
  assign vout_func_ok = (avs_writedata <= {26'h0, `VIO_FUNC_MAX_OUT});
  assign dly_ok       = (avs_writedata <= {16'h0, `VIO_DLY_MAX});

  // 0.1 s time base for the output delays
  // free-running, so the first tick of a delay may come up to one period early
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 32'h0;
    end else if (tick_cnt_r >= 32'(TICK_CYC - 1)) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end
  assign tick = (tick_cnt_r >= 32'(TICK_CYC - 1));

  // configuration registers
  // an out-of-range selector or delay write is dropped and the old value stays
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_V; i++) begin
        vin_func_r[i]  <= 6'h00;
        vout_func_r[i] <= 6'h00;
        vout_dly_r[i]  <= 16'h0000;
      end
      for (int i = 0; i < NUM_AN; i++) begin
        an_func_r[i] <= 6'h00;
      end
      vin_source_mode_r          <= 5'h00;
      vin_stored_level_r         <= 5'h00;
      vout_polarity_r            <= 5'h00;
      analog_as_input_polarity_r <= 3'h0;
      irq_mask_r                 <= 2'h0;
    end else if (wr_en) begin
      for (int i = 0; i < NUM_V; i++) begin
        if (avs_address == `VIO_OFS_VIN_FUNC0 + 8'(4 * i) && vin_func_ok)
          vin_func_r[i] <= avs_writedata[5:0];
        if (avs_address == `VIO_OFS_VOUT_FUNC0 + 8'(4 * i) && vout_func_ok)
          vout_func_r[i] <= avs_writedata[5:0];
        if (avs_address == `VIO_OFS_VOUT_DLY0 + 8'(4 * i) && dly_ok)
          vout_dly_r[i] <= avs_writedata[15:0];
      end
      for (int i = 0; i < NUM_AN; i++) begin
        if (avs_address == `VIO_OFS_AN_FUNC0 + 8'(4 * i) && vin_func_ok)
          an_func_r[i] <= avs_writedata[5:0];
      end
      case (avs_address)
        `VIO_OFS_VIN_MODE: begin
          vin_source_mode_r <= avs_writedata[NUM_V-1:0];
        end
        `VIO_OFS_VIN_LEVEL: begin
          vin_stored_level_r <= avs_writedata[NUM_V-1:0];
        end
        `VIO_OFS_AN_POL: begin
          analog_as_input_polarity_r <= avs_writedata[NUM_AN-1:0];
        end
        `VIO_OFS_VOUT_POL: begin
          vout_polarity_r <= avs_writedata[NUM_V-1:0];
        end
        `VIO_OFS_IRQ_MASK: begin
          irq_mask_r <= avs_writedata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // input synchronisers
  // analog words are synchronised bit by bit: a code must hold for several
  // cycles, or bits of two codes can mix in one sample
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phys_s1_r <= 5'h00;
      phys_s2_r <= 5'h00;
      an_s1_r   <= '0;
      an_s2_r   <= '0;
    end else begin
      phys_s1_r <= physical_input_line;
      phys_s2_r <= phys_s1_r;
      an_s1_r   <= analog_channel;
      an_s2_r   <= an_s1_r;
    end
  end

  // per-channel output path and analog hysteresis
  genvar g;
  generate
    for (g = 0; g < NUM_V; g++) begin : g_vout
      logic [15:0] dly_cnt_r;
      logic        pend_r;
      // selector 0 shorts to the terminal, otherwise the status function
      assign vout_raw[g] = (vout_func_r[g] == 6'h00) ? phys_s2_r[g]
                         : out_status_func[vout_func_r[g]];
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          vout_held_r[g] <= 1'b0;
          dly_cnt_r      <= 16'h0000;
          pend_r         <= 1'b0;
        end else if (vout_raw[g] == vout_held_r[g]) begin
          pend_r    <= 1'b0;
          dly_cnt_r <= 16'h0000;
        end else if (vout_dly_r[g] == 16'h0000) begin
          // zero delay follows the same cycle, no tick wait
          vout_held_r[g] <= vout_raw[g];
          pend_r         <= 1'b0;
        end else if (!pend_r) begin
          pend_r    <= 1'b1;
          dly_cnt_r <= vout_dly_r[g];
        end else if (tick) begin
          // a change that reverts before expiry is dropped
          if (dly_cnt_r == 16'h0001) begin
            vout_held_r[g] <= vout_raw[g];
            pend_r         <= 1'b0;
          end
          dly_cnt_r <= dly_cnt_r - 16'h0001;
        end
      end
      assign virtual_output[g] = vout_held_r[g] ^ vout_polarity_r[g];
      // combinational from the final output: no extra latency on the loop
      assign virtual_input[g] = vin_source_mode_r[g] ? vin_stored_level_r[g]
                              : virtual_output[g];
    end
    for (g = 0; g < NUM_AN; g++) begin : g_an
      // between the thresholds the flop keeps its state
      logic [AN_W-1:0] code;
      assign code = an_s2_r[g*AN_W +: AN_W];
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          an_level_r[g] <= 1'b0;
        end else if (code >= AN_HI) begin
          an_level_r[g] <= 1'b1;
        end else if (code <= AN_LO) begin
          an_level_r[g] <= 1'b0;
        end
      end
      assign analog_as_input[g] = an_level_r[g] ^ analog_as_input_polarity_r[g];
    end
  endgenerate

  // function decode across virtual and analog inputs
  // an analog input given a run or fault function acts like a terminal
  always_comb begin
    fwd_now    = 1'b0;
    ufault_now = 1'b0;
    for (int i = 0; i < NUM_V; i++) begin
      if (virtual_input[i] && vin_func_r[i] == `VIO_FUNC_FWD) fwd_now = 1'b1;
      if (virtual_input[i] && vin_func_r[i] == `VIO_FUNC_UFAULT1) ufault_now = 1'b1;
    end
    for (int i = 0; i < NUM_AN; i++) begin
      if (analog_as_input[i] && an_func_r[i] == `VIO_FUNC_FWD) fwd_now = 1'b1;
      if (analog_as_input[i] && an_func_r[i] == `VIO_FUNC_UFAULT1) ufault_now = 1'b1;
    end
  end
  assign fault_ev = ufault_now && !ufault_prev_r;

  // run state: one init cycle after reset, then evaluate; fault latches stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r       <= vio_pkg::VIO_ST_INIT;
      ufault_prev_r <= 1'b0;
    end else begin
      ufault_prev_r <= ufault_now;
      case (state_r)
        vio_pkg::VIO_ST_INIT: begin
          state_r <= vio_pkg::VIO_ST_RUN;
        end
        vio_pkg::VIO_ST_RUN: begin
          if (fault_ev) state_r <= vio_pkg::VIO_ST_FAULT;
        end
        vio_pkg::VIO_ST_FAULT: begin
          // fault clears only by writing one to its status bit
          // a new event in the clearing cycle keeps the drive stopped
          if (wr_en && avs_address == `VIO_OFS_IRQ_STAT && avs_writedata[0] && !fault_ev)
            state_r <= vio_pkg::VIO_ST_RUN;
        end
        default: begin
          state_r <= vio_pkg::VIO_ST_INIT;
        end
      endcase
    end
  end

  // status runs one cycle behind the inputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drive_status <= '0;
    end else begin
      drive_status.vin_active          <= virtual_input;
      // a fault arriving in the same cycle wins over a run request
      drive_status.forward_run_cmd     <= fwd_now && !fault_ev && (state_r == vio_pkg::VIO_ST_RUN);
      drive_status.user_fault          <= (state_r == vio_pkg::VIO_ST_FAULT) || fault_ev;
      drive_status.user_fault_one_code <= ((state_r == vio_pkg::VIO_ST_FAULT) || fault_ev)
                                          ? `VIO_USER_FAULT_ONE : 8'h00;
    end
  end

  // sticky events: bit0 user fault, bit1 any virtual output rise; set wins
  logic [NUM_V-1:0] vout_prev_r;
  // the clear is applied before the set, so an event in the clearing cycle stays
  assign irq_clr = (wr_en && avs_address == `VIO_OFS_IRQ_STAT) ? avs_writedata[1:0] : 2'h0;
  assign irq_set = {|(virtual_output & ~vout_prev_r), fault_ev};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_r  <= 2'h0;
      vout_prev_r <= 5'h00;
    end else begin
      vout_prev_r <= virtual_output;
      irq_stat_r  <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end
  // level output: stays high until software clears or masks the cause
  assign irq = |(irq_stat_r & irq_mask_r);

  // read data loaded in the wait cycle, then held through the accepting edge;
  // reloading there would let the word move as the master takes it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !rd_done_r) begin
      avs_readdata <= 32'h0;
      for (int i = 0; i < NUM_V; i++) begin
        if (avs_address == `VIO_OFS_VIN_FUNC0 + 8'(4 * i)) avs_readdata <= {26'h0, vin_func_r[i]};
        if (avs_address == `VIO_OFS_VOUT_FUNC0 + 8'(4 * i)) avs_readdata <= {26'h0, vout_func_r[i]};
        if (avs_address == `VIO_OFS_VOUT_DLY0 + 8'(4 * i)) avs_readdata <= {16'h0, vout_dly_r[i]};
      end
      for (int i = 0; i < NUM_AN; i++) begin
        if (avs_address == `VIO_OFS_AN_FUNC0 + 8'(4 * i)) avs_readdata <= {26'h0, an_func_r[i]};
      end
      case (avs_address)
        `VIO_OFS_VIN_MODE:  avs_readdata <= {27'h0, vin_source_mode_r};
        `VIO_OFS_VIN_LEVEL: avs_readdata <= {27'h0, vin_stored_level_r};
        `VIO_OFS_AN_POL:    avs_readdata <= {29'h0, analog_as_input_polarity_r};
        `VIO_OFS_VOUT_POL:  avs_readdata <= {27'h0, vout_polarity_r};
        `VIO_OFS_STATE:     avs_readdata <= {21'h0, state_r, analog_as_input, virtual_output};
        `VIO_OFS_IRQ_STAT:  avs_readdata <= {30'h0, irq_stat_r};
        `VIO_OFS_IRQ_MASK:  avs_readdata <= {30'h0, irq_mask_r};
        `VIO_OFS_VIN_STATE: avs_readdata <= {27'h0, virtual_input};
        default: begin
        end
      endcase
    end
  end
endmodule : vio_mapper

//--- vio_far.sv
/* far-side model: physical terminals, analog channels and drive status functions.
   assumes the bench calls its tasks from one process. */
`timescale 1ns/1ps
module vio_far (
  // clock
  input  wire logic    clk,
  // to the mapper
  output logic [4:0]   physical_input_line,
  output logic [35:0]  analog_channel,
  output logic [40:0]  out_status_func
);
  initial begin
    physical_input_line = 5'h00;
    analog_channel = 36'h0;
    out_status_func = 41'h0;
  end
  task automatic set_phys(input logic [4:0] v);
    @(posedge clk);
    physical_input_line <= v;
  endtask : set_phys
  // one jump per call; the mapper synchronises, so codes are held for several cycles
  task automatic set_an(input logic [11:0] v);
    @(posedge clk);
    analog_channel[11:0] <= v;
  endtask : set_an
  task automatic set_func(input int n, input logic v);
    @(posedge clk);
    out_status_func[n] <= v;
  endtask : set_func
endmodule : vio_far

//--- vio_mapper_assertions.sv
/* port checker for the vio mapper.
   assumes a bind from the bench; reads may stall, writes never do. */
`timescale 1ns/1ps
`include "vio_map.svh"
module vio_chk #(
  parameter int NUM_V  = 5,
  parameter int NUM_AN = 3,
  parameter int AN_W   = 12
) (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    nrst,
  // bus
  input wire logic [7:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  // far side
  input wire logic [NUM_V-1:0]        physical_input_line,
  input wire logic [NUM_AN*AN_W-1:0]  analog_channel,
  input wire logic [40:0]             out_status_func,
  // drive side
  input wire logic [NUM_V-1:0]        virtual_output,
  input wire logic [NUM_V-1:0]        virtual_input,
  input wire logic [NUM_AN-1:0]       analog_as_input,
  input vio_pkg::vio_status_type      drive_status,
  input wire logic                    irq
);
  // shadow of the registers the relations need
  logic [4:0]  mode_r, lvl_r, vpol_r;
  logic [2:0]  apol_r;
  logic [5:0]  vf0_r;
  logic [15:0] dly0_r;
  wire wr = avs_write && !avs_waitrequest;
  wire clr = wr && avs_address == `VIO_OFS_IRQ_STAT && avs_writedata[0];
  wire raw0 = (vf0_r == 6'h00) ? physical_input_line[0] : out_status_func[vf0_r];
  wire [AN_W-1:0] an0 = analog_channel[AN_W-1:0];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {mode_r, lvl_r, vpol_r, apol_r, vf0_r, dly0_r} <= '0;
    end else if (wr) begin
      case (avs_address)
        `VIO_OFS_VIN_MODE:   mode_r <= avs_writedata[4:0];
        `VIO_OFS_VIN_LEVEL:  lvl_r <= avs_writedata[4:0];
        `VIO_OFS_VOUT_POL:   vpol_r <= avs_writedata[4:0];
        `VIO_OFS_AN_POL:     apol_r <= avs_writedata[2:0];
        `VIO_OFS_VOUT_FUNC0: if (avs_writedata <= 32'h28) vf0_r <= avs_writedata[5:0];
        `VIO_OFS_VOUT_DLY0:  if (avs_writedata <= 32'h8ca0) dly0_r <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_fault_held;
    drive_status.user_fault [*2];
  endsequence
  sequence s_raw_settled;
    (dly0_r == 16'h0 && $stable(raw0)) [*4];
  endsequence
  chk_vin_source:
    assert property (virtual_input == ((mode_r & lvl_r) | (~mode_r & virtual_output))) else $error("vin source");
  chk_fault_code:
    assert property (drive_status.user_fault |-> drive_status.user_fault_one_code == 8'h1b) else $error("fault code");
  chk_code_idle:
    assert property (!drive_status.user_fault |-> drive_status.user_fault_one_code == 8'h00) else $error("idle code");
  chk_fault_latch:
    assert property (drive_status.user_fault && !clr && !$past(clr) |=> drive_status.user_fault) else $error("fault lost");
  chk_fault_stops:
    assert property (s_fault_held |-> !drive_status.forward_run_cmd) else $error("runs in fault");
  chk_ai_high:
    assert property ((an0 >= 12'hb33) [*4] |-> analog_as_input[0] == !apol_r[0]) else $error("analog high");
  chk_ai_low:
    assert property ((an0 <= 12'h4cc) [*4] |-> analog_as_input[0] == apol_r[0]) else $error("analog low");
  chk_vout_follow:
    assert property (s_raw_settled |-> virtual_output[0] == (raw0 ^ vpol_r[0])) else $error("vout follow");
endmodule : vio_chk

//--- tb.sv
/* self-checking bench for the vio mapper.
   assumes vio_far on the far side and a four-cycle delay tick. */
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} vio_row_type;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rval;
  logic [4:0]  physical_input_line, virtual_output, virtual_input;
  logic [35:0] analog_channel;
  logic [40:0] out_status_func;
  logic [2:0]  analog_as_input;
  vio_pkg::vio_status_type drive_status;
  int bad_count = 0, checked = 0, cyc = 0;
  vio_row_type rows [14] = '{'{8'h00, 32'h3b, 32'h3b}, '{8'h00, 32'h3c, 32'h3b}, '{8'h1c, 32'h3b, 32'h3b},
    '{8'h1c, 32'h3c, 32'h3b}, '{8'h2c, 32'h28, 32'h28}, '{8'h2c, 32'h29, 32'h28}, '{8'h2c, 32'h40, 32'h28},
    '{8'h40, 32'h8ca0, 32'h8ca0},
    '{8'h40, 32'h8ca1, 32'h8ca0}, '{8'h40, 32'h0, 32'h0}, '{8'h7c, 32'h5, 32'h0}, '{8'h00, 32'h0, 32'h0},
    '{8'h1c, 32'h0, 32'h0}, '{8'h2c, 32'h0, 32'h0}};
  logic [11:0] an_code [4] = '{12'hb33, 12'h7d0, 12'h4cc, 12'h7d0};
  logic        an_exp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0]  rst_adr [5] = '{8'h00, 8'h14, 8'h18, 8'h28, 8'h54};
  vio_mapper #(.TICK_CYC(4)) uut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .physical_input_line(physical_input_line), .analog_channel(analog_channel),
    .out_status_func(out_status_func), .virtual_output(virtual_output), .virtual_input(virtual_input),
    .analog_as_input(analog_as_input), .drive_status(drive_status), .irq(irq));
  vio_far far (.clk(clk), .physical_input_line(physical_input_line), .analog_channel(analog_channel),
    .out_status_func(out_status_func));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // a read leaves its data in rval, taken at the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rval = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    foreach (rst_adr[i]) begin
      bus(1'b0, rst_adr[i], 32'h0);
      check(rval, 32'h0);
    end
    bus(1'b0, 8'h58, 32'h0);
    check(rval[10:8], 3'h2);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      check(rval, rows[i].e);
    end
    bus(1'b1, 8'h14, 32'h1f);
    bus(1'b1, 8'h18, 32'h15);
    tick(1);
    check(virtual_input, 5'h15);
    check(drive_status.vin_active, 5'h15);
    bus(1'b0, 8'h64, 32'h0);
    check(rval, 32'h15);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h54, 32'h0a);
    far.set_phys(5'h13);
    tick(5);
    check(virtual_output, 5'h19);
    check(virtual_input, 5'h19);
    far.set_phys(5'h00);
    bus(1'b1, 8'h54, 32'h0);
    bus(1'b1, 8'h30, 32'h7);
    far.set_func(7, 1'b1);
    tick(4);
    check(virtual_output, 5'h02);
    far.set_func(7, 1'b0);
    bus(1'b1, 8'h30, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h14, 32'h1);
    bus(1'b1, 8'h18, 32'h1);
    tick(3);
    check(drive_status.forward_run_cmd, 1'b1);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h00, 32'h2c);
    bus(1'b1, 8'h2c, 32'h1f);
    far.set_func(31, 1'b1);
    tick(2);
    check(virtual_input[0], 1'b1);
    tick(2);
    check(drive_status.user_fault_one_code, 8'h1b);
    check(irq, 1'b0);
    bus(1'b0, 8'h58, 32'h0);
    check(rval[10:8], 3'h4);
    bus(1'b0, 8'h5c, 32'h0);
    check(rval, 32'h3);
    bus(1'b1, 8'h60, 32'h1);
    tick(1);
    check(irq, 1'b1);
    bus(1'b1, 8'h5c, 32'h3);
    tick(2);
    check({irq, drive_status.user_fault}, 2'b00);
    far.set_func(31, 1'b0);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h2c, 32'h0);
    bus(1'b1, 8'h48, 32'h3);
    far.set_phys(5'h04);
    tick(8);
    check(virtual_output[2], 1'b0);
    tick(12);
    check(virtual_output[2], 1'b1);
    foreach (an_code[i]) begin
      far.set_an(an_code[i]);
      tick(4);
      check(analog_as_input[0], an_exp[i]);
    end
    bus(1'b1, 8'h28, 32'h1);
    tick(1);
    check(analog_as_input[0], 1'b1);
    bus(1'b1, 8'h1c, 32'h1);
    tick(1);
    check(drive_status.forward_run_cmd, 1'b1);
    bus(1'b1, 8'h14, 32'h1f);
    bus(1'b1, 8'h18, 32'h1f);
    @(posedge clk);
    nrst <= 1'b0;
    tick(2);
    check({virtual_input, drive_status}, 20'h0);
    @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, 8'h18, 32'h0);
    check(rval, 32'h0);
    bus(1'b0, 8'h58, 32'h0);
    check(rval[10:8], 3'h2);
    conclude();
  end
endmodule : tb
bind vio_mapper vio_chk #(.NUM_V(NUM_V), .NUM_AN(NUM_AN), .AN_W(AN_W)) chk (.clk(clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .physical_input_line(physical_input_line),
  .analog_channel(analog_channel), .out_status_func(out_status_func), .virtual_output(virtual_output),
  .virtual_input(virtual_input), .analog_as_input(analog_as_input), .drive_status(drive_status), .irq(irq));
